// ===== rtl/fsdma_pkg.sv
// Constants, types and helpers for the four-stream DMA controller.
// Assumes one clock domain and a 16-bit register port.
package fsdma_pkg;
    localparam int NSTR = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] FIFO_BYTES = 7'h40;
    localparam logic [1:0] CTRL_ID_DEF = 2'h0;
    localparam logic [1:0] RR_LAST_RST = 2'h3;
    // Register index = byte offset / 4 inside a stream block
    localparam logic [3:0] REG_SRCL = 4'h0;
    localparam logic [3:0] REG_SRCH = 4'h1;
    localparam logic [3:0] REG_DSTL = 4'h2;
    localparam logic [3:0] REG_DSTH = 4'h3;
    localparam logic [3:0] REG_MAX = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h5;
    localparam logic [3:0] REG_TC = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [2:0] BLK_GLOBAL = 3'h4;
    // Control word fields
    localparam int CB_EN = 0;
    localparam int CB_SOINC = 1;
    localparam int CB_DEINC = 2;
    localparam int CB_SOSZ = 3;
    localparam int CB_BURST = 5;
    localparam int CB_DESZ = 7;
    localparam int CB_CIRC = 9;
    localparam int CB_DIR = 13;
    localparam int CB_MCOPY = 14;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD = 4'h2,
        ST_GAP = 4'h4,
        ST_WR = 4'h8
    } fsdma_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic rd;
        logic wr;
    } fsdma_bus_s;

    function automatic logic [2:0] fsdma_unit_bytes(input logic [1:0] code);
        unique case (code)
            2'h0: fsdma_unit_bytes = 3'h1;
            2'h1: fsdma_unit_bytes = 3'h2;
            default: fsdma_unit_bytes = 3'h4;
        endcase
    endfunction

    function automatic logic [4:0] fsdma_burst_units(input logic [1:0] code);
        unique case (code)
            2'h0: fsdma_burst_units = 5'h01;
            2'h1: fsdma_burst_units = 5'h04;
            2'h2: fsdma_burst_units = 5'h08;
            default: fsdma_burst_units = 5'h10;
        endcase
    endfunction
endpackage

// ===== rtl/fsdma_top.sv
// Four-stream DMA controller: stream registers, shared packing FIFO,
// burst engine and the round-robin bus arbiter among four controllers.
// Assumes requests, peer bus requests and the bus answer share mclk.
`timescale 1ns/100ps
`default_nettype none

module fsdma_top #(
    parameter logic [1:0] CTRL_ID = fsdma_pkg::CTRL_ID_DEF
) (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [8:0] reg_addr, // Register byte address
    input wire logic [15:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [3:0] periph_req, // Peripheral request levels
    input wire logic [3:0] peer_bus_req, // Bus requests of the other controllers; own bit unused
    output logic [3:0] bus_gnt, // Arbiter grant, one-hot
    output logic bus_req, // This controller wants the bus
    output fsdma_pkg::fsdma_bus_s bus_out, // Bus command
    input wire logic bus_ack, // Beat accepted or data valid
    input wire logic [31:0] bus_rdata, // Read data with ack
    output logic irq // Completion interrupt
);
    logic [15:0] srcl_reg [fsdma_pkg::NSTR];
    logic [15:0] srch_reg [fsdma_pkg::NSTR];
    logic [15:0] dstl_reg [fsdma_pkg::NSTR];
    logic [15:0] dsth_reg [fsdma_pkg::NSTR];
    logic [15:0] max_reg [fsdma_pkg::NSTR];
    logic [15:0] ctrl_reg [fsdma_pkg::NSTR];
    logic [15:0] tc_reg [fsdma_pkg::NSTR];
    logic [31:0] scur_reg [fsdma_pkg::NSTR];
    logic [31:0] dcur_reg [fsdma_pkg::NSTR];
    logic [31:0] fifo_mem [fsdma_pkg::FIFO_DEPTH];
    logic [5:0] wp_reg, rp_reg, rbase;
    logic [6:0] fill_reg, fill_av, rd_need, wr_need, free_b;
    fsdma_pkg::fsdma_state_e st_reg;
    fsdma_pkg::fsdma_bus_s bus_reg;
    logic [1:0] cur_reg, pick, sel, last_reg, rr_idx;
    logic [4:0] beat_reg, blen;
    logic [2:0] wnb_reg, ssz, dsz, nb;
    logic [3:0] flag_reg, flag_next, gnt_reg, arb_req, pending, req_eff;
    logic [15:0] rdata_reg, rd_mux, cc, tcc, ld_max;
    logic irq_reg, bus_req_reg, rr_hit, grant, flush, can_rd, can_wr;
    logic push, pop, done, sw_stream, en_load;
    logic [31:0] s_next, d_next, d_addr, rx_word, tx_word;
    logic [5:0] wpos [4];
    logic [5:0] rpos [4];
    logic [1:0] sw_s;

    assign sw_s = reg_addr[7:6];
    // Upper half of the map holds only status; stream writes there would alias
    assign sw_stream = reg_wr && reg_addr[8] == 1'b0;
    assign ld_max = max_reg[sw_s];
    assign en_load = sw_stream && reg_addr[5:2] == fsdma_pkg::REG_CTRL
        && reg_wdata[fsdma_pkg::CB_EN] && !ctrl_reg[sw_s][fsdma_pkg::CB_EN];

    assign cc = ctrl_reg[cur_reg];
    assign tcc = tc_reg[cur_reg];
    assign ssz = fsdma_pkg::fsdma_unit_bytes(cc[fsdma_pkg::CB_SOSZ+:2]);
    assign dsz = fsdma_pkg::fsdma_unit_bytes(cc[fsdma_pkg::CB_DESZ+:2]);
    assign blen = fsdma_pkg::fsdma_burst_units(cc[fsdma_pkg::CB_BURST+:2]);
    assign rd_need = 7'(blen * ssz);
    assign wr_need = 7'(blen * dsz);
    assign free_b = fsdma_pkg::FIFO_BYTES - fill_reg;
    // Disable or zero count drains whatever is left, even a partial unit
    assign flush = !cc[fsdma_pkg::CB_EN] || tcc == 16'h0000;
    // Request 0 side: room for one source burst
    assign can_rd = cc[fsdma_pkg::CB_EN] && tcc != 16'h0000 && free_b >= rd_need;
    // Request 1 side: a full burst or a flush
    assign can_wr = fill_reg >= wr_need || (flush && fill_reg != 7'h00);

    assign push = st_reg == fsdma_pkg::ST_RD && bus_reg.rd && bus_ack;
    assign pop = st_reg == fsdma_pkg::ST_WR && bus_reg.wr && bus_ack;
    assign fill_av = pop ? fill_reg - 7'(wnb_reg) : fill_reg;
    assign rbase = pop ? rp_reg + 6'(wnb_reg) : rp_reg;
    assign nb = (flush && fill_av < 7'(dsz)) ? fill_av[2:0] : dsz;
    // Peripherals are plain addresses; increment is per stream
    assign s_next = scur_reg[cur_reg] + (cc[fsdma_pkg::CB_SOINC] ? 32'(ssz) : 32'h0);
    assign d_next = dcur_reg[cur_reg] + (cc[fsdma_pkg::CB_DEINC] ? 32'(wnb_reg) : 32'h0);
    assign d_addr = pop ? d_next : dcur_reg[cur_reg];
    // Lowest address lane is least significant byte
    assign rx_word = bus_rdata >> {bus_reg.addr[1:0], 3'h0};

    always_comb
    begin
        tx_word = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            wpos[i] = wp_reg + 6'(i);
            rpos[i] = rbase + 6'(i);
            tx_word[8*i+:8] = fifo_mem[rpos[i][5:2]][{rpos[i][1:0], 3'h0}+:8];
        end
    end

    // Copy mode replaces the stream 3 pin with internal requests
    always_comb
    begin
        req_eff = periph_req;
        if (ctrl_reg[3][fsdma_pkg::CB_MCOPY])
            req_eff[3] = 1'b1;
        for (int i = 0; i < fsdma_pkg::NSTR; i++)
            pending[i] = ctrl_reg[i][fsdma_pkg::CB_EN]
                && (req_eff[i] || tc_reg[i] == 16'h0000);
    end

    always_comb
    begin
        pick = cur_reg;
        for (int i = fsdma_pkg::NSTR - 1; i >= 0; i--)
            if (pending[i])
                pick = 2'(i);
    end

    // FIFO stays with one stream until it is empty
    assign sel = (fill_reg != 7'h00) ? cur_reg : pick;
    // Zero count and drained FIFO ends the transfer
    assign done = st_reg == fsdma_pkg::ST_IDLE && sel == cur_reg
        && cc[fsdma_pkg::CB_EN] && tcc == 16'h0000 && fill_reg == 7'h00;
    assign grant = gnt_reg[CTRL_ID];

    // Search from last user plus one, wrapping
    always_comb
    begin
        arb_req = peer_bus_req;
        arb_req[CTRL_ID] = bus_req_reg;
        rr_hit = 1'b0;
        rr_idx = last_reg;
        for (int k = 1; k <= 4; k++)
            if (!rr_hit && arb_req[2'(last_reg + 2'(k))])
            begin
                rr_hit = 1'b1;
                rr_idx = 2'(last_reg + 2'(k));
            end
    end

    // Last user starts as controller 3
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gnt_reg <= 4'h0;
            last_reg <= fsdma_pkg::RR_LAST_RST;
        end
        // Owner keeps the bus while it still asks
        else if ((gnt_reg & arb_req) == 4'h0)
        begin
            gnt_reg <= rr_hit ? 4'(4'h1 << rr_idx) : 4'h0;
            if (rr_hit)
                last_reg <= rr_idx;
        end
    end

    // Stream registers, written by software and by the engine
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < fsdma_pkg::NSTR; i++)
            begin
                srcl_reg[i] <= 16'h0;
                srch_reg[i] <= 16'h0;
                dstl_reg[i] <= 16'h0;
                dsth_reg[i] <= 16'h0;
                max_reg[i] <= 16'h0;
                ctrl_reg[i] <= fsdma_pkg::CTRL_RST;
                tc_reg[i] <= 16'h0;
                scur_reg[i] <= 32'h0;
                dcur_reg[i] <= 32'h0;
            end
        end
        else
        begin
            // Count falls by one source unit
            if (push)
            begin
                tc_reg[cur_reg] <= tcc - 16'h1;
                scur_reg[cur_reg] <= s_next;
            end
            if (pop)
                dcur_reg[cur_reg] <= d_next;
            if (done)
                ctrl_reg[cur_reg][fsdma_pkg::CB_EN] <= 1'b0;
            // Software after hardware: a re-enable beats the clear
            if (sw_stream)
                unique case (reg_addr[5:2])
                    fsdma_pkg::REG_SRCL: srcl_reg[sw_s] <= reg_wdata;
                    fsdma_pkg::REG_SRCH: srch_reg[sw_s] <= reg_wdata;
                    fsdma_pkg::REG_DSTL: dstl_reg[sw_s] <= reg_wdata;
                    fsdma_pkg::REG_DSTH: dsth_reg[sw_s] <= reg_wdata;
                    fsdma_pkg::REG_MAX: max_reg[sw_s] <= reg_wdata;
                    fsdma_pkg::REG_CTRL: ctrl_reg[sw_s] <= reg_wdata;
                    default: ;
                endcase
            // Enable loads count and start addresses
            if (en_load)
            begin
                tc_reg[sw_s] <= ld_max;
                scur_reg[sw_s] <= {srch_reg[sw_s], srcl_reg[sw_s]};
                dcur_reg[sw_s] <= {dsth_reg[sw_s], dstl_reg[sw_s]};
            end
        end
    end

    // Byte-granular pack on push, unpack on pop
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 4; i++)
            if (push && 3'(i) < ssz)
                fifo_mem[wpos[i][5:2]][{wpos[i][1:0], 3'h0}+:8] <= rx_word[8*i+:8];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_reg <= 6'h0;
            rp_reg <= 6'h0;
            fill_reg <= 7'h0;
        end
        else
        begin
            if (push)
                wp_reg <= wp_reg + 6'(ssz);
            rp_reg <= rbase;
            fill_reg <= fill_av + (push ? 7'(ssz) : 7'h0);
        end
    end

    // Burst engine: read burst, gap, write burst
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= fsdma_pkg::ST_IDLE;
            cur_reg <= 2'h0;
            beat_reg <= 5'h0;
            wnb_reg <= 3'h0;
            bus_reg <= '0;
            bus_req_reg <= 1'b0;
        end
        else
        begin
            unique case (st_reg)
                fsdma_pkg::ST_IDLE:
                begin
                    if (sel != cur_reg)
                        cur_reg <= sel;
                    // Request with room starts a read burst
                    else if (!done && req_eff[cur_reg] && can_rd)
                    begin
                        st_reg <= fsdma_pkg::ST_RD;
                        beat_reg <= (tcc < 16'(blen)) ? tcc[4:0] : blen;
                        bus_req_reg <= 1'b1;
                    end
                    else if (!done && can_wr && (req_eff[cur_reg] || flush))
                    begin
                        st_reg <= fsdma_pkg::ST_WR;
                        beat_reg <= blen;
                        bus_req_reg <= 1'b1;
                    end
                end
                fsdma_pkg::ST_RD:
                begin
                    if (!bus_reg.rd)
                    begin
                        if (grant)
                        begin
                            bus_reg.rd <= 1'b1;
                            bus_reg.addr <= scur_reg[cur_reg];
                            bus_reg.be <= 4'hf;
                        end
                    end
                    else if (bus_ack)
                    begin
                        beat_reg <= beat_reg - 5'h1;
                        bus_reg.addr <= s_next;
                        if (beat_reg == 5'h1)
                        begin
                            bus_reg.rd <= 1'b0;
                            bus_req_reg <= 1'b0;
                            st_reg <= fsdma_pkg::ST_GAP;
                        end
                    end
                end
                // Single latency cycle before the write phase
                fsdma_pkg::ST_GAP:
                begin
                    st_reg <= can_wr ? fsdma_pkg::ST_WR : fsdma_pkg::ST_IDLE;
                    bus_req_reg <= can_wr;
                    beat_reg <= blen;
                end
                fsdma_pkg::ST_WR:
                begin
                    if (!bus_reg.wr || bus_ack)
                    begin
                        if (bus_reg.wr)
                            beat_reg <= beat_reg - 5'h1;
                        if ((bus_reg.wr && beat_reg == 5'h1) || fill_av == 7'h0)
                        begin
                            bus_reg.wr <= 1'b0;
                            bus_req_reg <= 1'b0;
                            st_reg <= fsdma_pkg::ST_IDLE;
                        end
                        // Unit placed on its address lanes
                        else if (grant)
                        begin
                            bus_reg.wr <= 1'b1;
                            bus_reg.addr <= d_addr;
                            bus_reg.wdata <= tx_word << {d_addr[1:0], 3'h0};
                            bus_reg.be <= 4'(((5'h1 << nb) - 5'h1) << d_addr[1:0]);
                            wnb_reg <= nb;
                        end
                    end
                end
                default: st_reg <= fsdma_pkg::ST_IDLE;
            endcase
        end
    end

    // Flag set wins over a write-one clear
    always_comb
    begin
        flag_next = flag_reg;
        if (reg_wr && reg_addr[8:6] == fsdma_pkg::BLK_GLOBAL
            && reg_addr[5:2] == fsdma_pkg::REG_STATUS)
            flag_next = flag_next & ~reg_wdata[3:0];
        if (done)
            flag_next[cur_reg] = 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= 4'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            // Interrupt is the OR of the flags
            irq_reg <= |flag_next;
        end
    end

    always_comb
    begin
        rd_mux = 16'h0;
        if (reg_addr[8:6] == fsdma_pkg::BLK_GLOBAL)
        begin
            if (reg_addr[5:2] == fsdma_pkg::REG_STATUS)
                rd_mux = {12'h0, flag_reg};
        end
        else if (reg_addr[8] == 1'b0)
            unique case (reg_addr[5:2])
                fsdma_pkg::REG_SRCL: rd_mux = srcl_reg[sw_s];
                fsdma_pkg::REG_SRCH: rd_mux = srch_reg[sw_s];
                fsdma_pkg::REG_DSTL: rd_mux = dstl_reg[sw_s];
                fsdma_pkg::REG_DSTH: rd_mux = dsth_reg[sw_s];
                fsdma_pkg::REG_MAX: rd_mux = max_reg[sw_s];
                fsdma_pkg::REG_CTRL: rd_mux = ctrl_reg[sw_s];
                fsdma_pkg::REG_TC: rd_mux = tc_reg[sw_s];
                default: rd_mux = 16'h0;
            endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= 16'h0;
        else
            rdata_reg <= reg_rd ? rd_mux : 16'h0;
    end

    assign reg_rdata = rdata_reg;
    assign bus_gnt = gnt_reg;
    assign bus_req = bus_req_reg;
    assign bus_out = bus_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_irq_or: assert property (irq_reg == |flag_reg)
        else $error("irq differs from OR of flags");
    chk_done_flag: assert property (done
        && !(sw_stream && sw_s == cur_reg && reg_addr[5:2] == fsdma_pkg::REG_CTRL)
        |=> flag_reg[$past(cur_reg)] && !ctrl_reg[$past(cur_reg)][fsdma_pkg::CB_EN])
        else $error("completion did not flag and disable");
    chk_en_load: assert property (en_load |=> tc_reg[$past(sw_s)] == $past(ld_max))
        else $error("enable did not load terminal count");
    chk_gap_one: assert property (push && beat_reg == 5'h1
        |=> st_reg == fsdma_pkg::ST_GAP ##1 st_reg != fsdma_pkg::ST_GAP)
        else $error("gap not exactly one cycle");
    chk_tc_step: assert property (push |=> tc_reg[$past(cur_reg)] == $past(tcc) - 16'h1)
        else $error("terminal count did not step");
    chk_rr_pick: assert property ((gnt_reg & arb_req) == 4'h0 && rr_hit
        |=> gnt_reg == 4'(4'h1 << $past(rr_idx)) && $onehot(gnt_reg))
        else $error("round-robin grant wrong");
    chk_prio_pick: assert property (st_reg == fsdma_pkg::ST_IDLE && fill_reg == 7'h0
        && pending[0] && cur_reg != 2'h0 |=> cur_reg == 2'h0)
        else $error("stream 0 not preferred");
    chk_fifo_cap: assert property (fill_reg <= fsdma_pkg::FIFO_BYTES
        && (!push || free_b >= 7'(ssz)))
        else $error("FIFO overfilled");
endmodule
`default_nettype wire

// ===== verif/fsdma_mem_model.sv
// Bus slave model: a small word memory behind the burst bus.
// Assumes commands held until ack, as the controller promises.
`timescale 1ns/100ps
`default_nettype none
module fsdma_mem_model (
    input wire logic mclk, // System clock
    input wire logic slow, // One wait cycle per beat
    input wire fsdma_pkg::fsdma_bus_s cmd, // Bus command
    output logic ack, // Beat done
    output logic [31:0] rdata // Read data with ack
);
    logic [31:0] mem [0:63];
    logic wait_reg = 1'b0;
    logic [31:0] junk_reg = 32'h0000_0000;
    logic busy;
    assign busy = cmd.rd | cmd.wr;
    assign ack = busy && (!slow || wait_reg);
    assign rdata = (ack && cmd.rd) ? mem[cmd.addr[7:2]] : junk_reg;
    // Bench preloads memory, so no always_ff here
    always @(posedge mclk)
    begin
        junk_reg <= ~junk_reg;
        wait_reg <= busy && !ack;
        if (ack && cmd.wr)
        begin
            for (int b = 0; b < 4; b++)
                if (cmd.be[b])
                    mem[cmd.addr[7:2]][8*b +: 8] <= cmd.wdata[8*b +: 8];
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_four_stream_dma_controller.sv
// Self-checking bench for the four-stream DMA controller.
// Assumes the memory model on the bus; peer requests driven here.
`timescale 1ns/100ps
`default_nettype none
module test_four_stream_dma_controller;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] periph_req = 4'h0;
    logic [3:0] peer_bus_req = 4'h0;
    logic [3:0] bus_gnt;
    logic bus_req;
    fsdma_pkg::fsdma_bus_s bus_out;
    logic bus_ack;
    logic [31:0] bus_rdata;
    logic irq;
    logic slow = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;

    always #5 mclk = ~mclk;

    fsdma_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .periph_req(periph_req),
        .peer_bus_req(peer_bus_req), .bus_gnt(bus_gnt), .bus_req(bus_req),
        .bus_out(bus_out), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .irq(irq));
    fsdma_mem_model slave (.mclk(mclk), .slow(slow), .cmd(bus_out),
        .ack(bus_ack), .rdata(bus_rdata));

    // Each byte holds its own address
    function automatic logic [31:0] pat(input int w);
        pat = {8'(w*4+3), 8'(w*4+2), 8'(w*4+1), 8'(w*4)};
    endfunction

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [8:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [8:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic reg_check(input logic [8:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        reg_read(a, d);
        check(what, {16'h0000, exp}, {16'h0000, d});
    endtask

    task automatic prog(input int s, input logic [15:0] src, dst, cnt, ctrl);
        logic [8:0] b;
        b = 9'(s * 64);
        reg_write(b, src);
        reg_write(b + 9'h004, 16'h0000);
        reg_write(b + 9'h008, dst);
        reg_write(b + 9'h00c, 16'h0000);
        reg_write(b + 9'h010, cnt);
        reg_write(b + 9'h014, ctrl);
    endtask

    // Poll status; a bounded loop keeps a stuck stream from hanging
    task automatic wait_status(input logic [15:0] mask);
        logic [15:0] d;
        d = 16'h0000;
        for (int i = 0; i < 300 && (d & mask) !== mask; i++)
            reg_read(9'h100, d);
        check("status", {16'h0000, mask}, {16'h0000, d & mask});
    endtask

    task automatic test_rr;
        logic [3:0] peers [5] = '{4'h6, 4'hc, 4'ha, 4'h2, 4'h0};
        logic [3:0] grants [5] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h0};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            peer_bus_req <= peers[i];
            repeat (3) @(posedge mclk);
            #1;
            check("grant", {28'h0, grants[i]}, {28'h0, bus_gnt});
        end
    endtask

    task automatic test_regs;
        reg_check(9'h054, 16'h0000, "ctrl1 reset");
        reg_write(9'h040, 16'hbeef);
        reg_write(9'h140, 16'hdead);
        reg_check(9'h040, 16'hbeef, "src low 1");
        reg_write(9'h058, 16'h1234);
        reg_check(9'h058, 16'h0000, "tc read only");
        reg_check(9'h1fc, 16'h0000, "unmapped");
        check("irq idle", 32'h0, {31'h0, irq});
        check("bus req idle", 32'h0, {31'h0, bus_req});
    endtask

    task automatic test_flow;
        prog(0, 16'h0000, 16'h0080, 16'h0004, 16'h0137);
        prog(2, 16'h0020, 16'h00a0, 16'h0004, 16'h0137);
        reg_check(9'h018, 16'h0004, "tc load");
        @(posedge mclk);
        periph_req <= 4'h5;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge mclk);
            #1;
            if (bus_out.rd === 1'b1)
                break;
        end
        check("first source", 32'h0, bus_out.addr);
        check("bus req", 32'h1, {31'h0, bus_req});
        wait_status(16'h0005);
        @(posedge mclk);
        periph_req <= 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            check("dest s0", pat(i), slave.mem[32 + i]);
            check("dest s2", pat(8 + i), slave.mem[40 + i]);
        end
        check("irq set", 32'h1, {31'h0, irq});
        reg_check(9'h014, 16'h0136, "enable cleared");
        reg_check(9'h018, 16'h0000, "tc zero");
        reg_write(9'h100, 16'h0005);
        repeat (2) @(posedge mclk);
        #1;
        check("irq clear", 32'h0, {31'h0, irq});
        reg_write(9'h014, 16'h0137);
        reg_check(9'h018, 16'h0004, "tc reload");
        reg_write(9'h014, 16'h0136);
    endtask

    task automatic test_pack;
        @(posedge mclk);
        slow <= 1'b1;
        prog(1, 16'h0010, 16'h00c0, 16'h0004, 16'h0127);
        periph_req <= 4'h2;
        wait_status(16'h0002);
        @(posedge mclk);
        periph_req <= 4'h0;
        slow <= 1'b0;
        check("packed word", pat(4), slave.mem[48]);
        check("no spill", pat(49), slave.mem[49]);
        reg_write(9'h100, 16'h0002);
    endtask

    task automatic test_copy;
        // Word source, half-word destination: unpack onto upper lanes too
        prog(3, 16'h0000, 16'h00e0, 16'h0002, 16'h40b7);
        wait_status(16'h0008);
        check("copy 0", pat(0), slave.mem[56]);
        check("copy 1", pat(1), slave.mem[57]);
        check("copy tail", pat(58), slave.mem[58]);
        check("irq copy", 32'h1, {31'h0, irq});
        reg_write(9'h100, 16'h0008);
    endtask

    initial
    begin
        for (int i = 0; i < 64; i++)
            slave.mem[i] = pat(i);
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        test_rr();
        test_regs();
        // Stream 1 first, so stream 0 must win the FIFO back
        test_pack();
        test_flow();
        test_copy();
        end_of_test();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
